// *** rtl/sepc_ctrl.sv ***
// Serial EEPROM pin-level controller: command capture, read-out, status
// Summary of operation
// - Start, opcode, address, data captured per clock
// - Read bits driven after rising serial clock
// - Status shown on select rise after deselect
// - Select low whole cycle keeps output high-Z
// - Status after completion drives output high
// - Start bit then deselect clears status
// - Strap high selects sixteen-bit words
// - Strap low selects eight-bit words
// - Strapless variants use fixed word width
// - Permit high allows array programming
// - Permit low inhibits all programming
// - Permitless variants always allow programming
// - Status low while busy, high ready
// - Deselect resets control, programming completes
`timescale 1ns/100ps
module sepc_ctrl
  import sepc_pkg::*;
#(
  parameter logic [1:0] WIDTH_SEL = WSEL_STRAP,
  parameter bit HAS_PERMIT = 1'b1,
  parameter int PROG_CYCLES = PROG_CYC
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_chip_select,
  input wire logic i_serial_clock,
  input wire logic i_serial_in,
  input wire logic i_word_width_strap,
  input wire logic i_program_permit,
  output logic o_serial_out,
  output logic o_serial_out_en
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic [PIN_COUNT-1:0] pins_async;
  logic [PIN_COUNT-1:0] pins_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  logic cs_s;
  logic din_s;
  assign pins_async = {i_program_permit, i_word_width_strap, i_serial_in,
                       i_chip_select, i_serial_clock};
  sepc_sync #(.W(PIN_COUNT)) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_async),
    .o_sync(pins_s)
  );
  assign cs_s = pins_s[PIN_CS];
  assign din_s = pins_s[PIN_SIN];
  assign sclk_rise = pins_s[PIN_SCLK] && !sclk_prev_q;
  assign cs_rise = cs_s && !cs_prev_q;
  assign cs_fall = !cs_s && cs_prev_q;
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= pins_s[PIN_SCLK];
      cs_prev_q <= cs_s;
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [4:0] addr_bits(input logic x16);
    return x16 ? ADDR_BITS_X16 : ADDR_BITS_X8;
  endfunction
  function automatic logic [4:0] data_bits(input logic x16);
    return x16 ? DATA_BITS_X16 : DATA_BITS_X8;
  endfunction
  // Strapless variants ignore the pin
  function automatic logic width_of(input logic strap);
    if (WIDTH_SEL == WSEL_X8)
      return 1'b0;
    else if (WIDTH_SEL == WSEL_X16)
      return 1'b1;
    else
      return strap;
  endfunction
  // ==========================================================
  // Deselect timer and configuration capture
  logic [5:0] csl_cnt_q;
  logic csl_ok;
  logic x16_q;
  logic permit_q;
  assign csl_ok = (csl_cnt_q >= 6'(CSL_CYC));
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      csl_cnt_q <= '0;
    else if (cs_s)
      csl_cnt_q <= '0;
    else if (!csl_ok)
      csl_cnt_q <= csl_cnt_q + 6'h01;
  end
  // Latched on select rise so one command sees one setting
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      x16_q <= 1'b0;
      permit_q <= 1'b0;
    end
    else if (cs_rise)
    begin
      x16_q <= width_of(pins_s[PIN_STRAP]);
      permit_q <= HAS_PERMIT ? pins_s[PIN_PERMIT] : 1'b1;
    end
  end
  // ==========================================================
  // Command capture
  sepc_state_t state_q;
  logic [4:0] cnt_q;
  logic [1:0] opc_q;
  logic [9:0] addr_q;
  logic [15:0] data_q;
  logic [9:0] addr_nx;
  logic last_addr;
  logic last_data;
  logic prog_go;
  logic prog_erase;
  logic busy_q;
  assign addr_nx = {addr_q[8:0], din_s};
  assign last_addr = (state_q == ST_ADDR) && sclk_rise && (cnt_q == addr_bits(x16_q) - 5'h01);
  assign last_data = (state_q == ST_DATA) && sclk_rise && (cnt_q == data_bits(x16_q) - 5'h01);
  assign prog_erase = last_addr && (opc_q == OPC_ERASE);
  assign prog_go = cs_s && (prog_erase || last_data);
  // Bits shift in on each rising serial clock; deselect resets
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      opc_q <= '0;
      addr_q <= '0;
      data_q <= '0;
    end
    else if (!cs_s)
      state_q <= ST_IDLE;
    else if (sclk_rise)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (din_s)
          begin
            state_q <= ST_OPC;
            cnt_q <= '0;
          end
        end
        ST_OPC:
        begin
          opc_q <= {opc_q[0], din_s};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == OPC_BITS - 5'h01)
          begin
            state_q <= ST_ADDR;
            cnt_q <= '0;
          end
        end
        ST_ADDR:
        begin
          addr_q <= addr_nx;
          cnt_q <= cnt_q + 5'h01;
          if (last_addr)
          begin
            cnt_q <= '0;
            if (opc_q == OPC_READ)
              state_q <= ST_READ;
            else if (opc_q == OPC_WRITE)
              state_q <= ST_DATA;
            else
              state_q <= ST_DONE;
          end
        end
        ST_DATA:
        begin
          data_q <= {data_q[14:0], din_s};
          cnt_q <= cnt_q + 5'h01;
          if (last_data)
            state_q <= ST_DONE;
        end
        default: state_q <= state_q;
      endcase
    end
  end
  // ==========================================================
  // Self-timed programming
  logic prog_ok;
  logic [23:0] prog_cnt_q;
  logic [9:0] pa;
  logic [15:0] pd;
  logic [15:0] mem_q [WORDS];
  assign prog_ok = prog_go && permit_q && !busy_q;
  assign pa = prog_erase ? addr_nx : addr_q;
  assign pd = prog_erase ? 16'hFFFF : {data_q[14:0], din_s};
  // Timer keeps running through deselect
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
    end
    else if (prog_ok)
    begin
      busy_q <= 1'b1;
      prog_cnt_q <= 24'(PROG_CYCLES - 1);
    end
    else if (busy_q)
    begin
      if (prog_cnt_q == 24'h000000)
        busy_q <= 1'b0;
      else
        prog_cnt_q <= prog_cnt_q - 24'h000001;
    end
  end
  // Array update; eight-bit mode writes one byte lane
  always_ff @(posedge i_clock)
  begin
    if (prog_ok)
    begin
      if (x16_q)
        mem_q[pa[8:0]] <= pd;
      else if (pa[0])
        mem_q[pa[9:1]][7:0] <= pd[7:0];
      else
        mem_q[pa[9:1]][15:8] <= pd[7:0];
    end
  end
  // ==========================================================
  // Read-ahead into the FIFO; stalls when it is full
  sepc_fifo_if #(.WIDTH(16)) ff ();
  logic fetch_on_q;
  logic [9:0] fptr_q;
  logic [15:0] fword;
  sepc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .f(ff.fifo)
  );
  assign fword = mem_q[x16_q ? fptr_q[8:0] : fptr_q[9:1]];
  assign ff.wr_valid = fetch_on_q;
  assign ff.wr_data = x16_q ? fword : {(fptr_q[0] ? fword[7:0] : fword[15:8]), 8'h00};
  assign ff.flush = !cs_s;
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fetch_on_q <= 1'b0;
      fptr_q <= '0;
    end
    else if (!cs_s)
      fetch_on_q <= 1'b0;
    else if (last_addr && opc_q == OPC_READ)
    begin
      fetch_on_q <= 1'b1;
      fptr_q <= x16_q ? {1'b0, addr_nx[8:0]} : addr_nx;
    end
    else if (fetch_on_q && ff.wr_ready)
      fptr_q <= x16_q ? {1'b0, fptr_q[8:0] + 9'h001} : fptr_q + 10'h001;
  end
  // ==========================================================
  // Read shifter: dummy zero, then words MSB first, sequential
  logic rd_act_q;
  logic [15:0] sh_q;
  logic [4:0] left_q;
  logic read_bit_q;
  assign ff.rd_ready = rd_act_q && cs_s && sclk_rise && (left_q == 5'h00);
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rd_act_q <= 1'b0;
      sh_q <= '0;
      left_q <= '0;
      read_bit_q <= 1'b0;
    end
    else if (!cs_s)
      rd_act_q <= 1'b0;
    else if (last_addr && opc_q == OPC_READ)
    begin
      rd_act_q <= 1'b1;
      read_bit_q <= 1'b0;
      left_q <= '0;
    end
    else if (rd_act_q && sclk_rise)
    begin
      if (left_q == 5'h00)
      begin
        // An empty FIFO here means the clock outran the fetch
        read_bit_q <= ff.rd_valid && ff.rd_data[15];
        sh_q <= {ff.rd_data[14:0], 1'b0};
        left_q <= data_bits(x16_q) - 5'h01;
      end
      else
      begin
        read_bit_q <= sh_q[15];
        sh_q <= {sh_q[14:0], 1'b0};
        left_q <= left_q - 5'h01;
      end
    end
  end
  // ==========================================================
  // Ready/busy status presentation
  logic stat_pend_q;
  logic stat_show_q;
  logic start_seen_q;
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      start_seen_q <= 1'b0;
    else if (!cs_s)
      start_seen_q <= 1'b0;
    else if (prog_ok)
      start_seen_q <= 1'b0;
    else if (state_q == ST_IDLE && sclk_rise && din_s)
      start_seen_q <= 1'b1;
  end
  // Program start wins over a clear in the same cycle
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stat_pend_q <= 1'b0;
      stat_show_q <= 1'b0;
    end
    else
    begin
      if (prog_ok)
        stat_pend_q <= 1'b1;
      else if (cs_fall && start_seen_q)
        stat_pend_q <= 1'b0;
      if (!cs_s)
        stat_show_q <= 1'b0;
      else if (cs_rise && csl_ok && stat_pend_q)
        stat_show_q <= 1'b1;
    end
  end
  // ==========================================================
  // Output pin; read data takes precedence over status
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_serial_out <= 1'b0;
      o_serial_out_en <= 1'b0;
    end
    else if (!cs_s)
      o_serial_out_en <= 1'b0;
    else if (rd_act_q)
    begin
      o_serial_out_en <= 1'b1;
      o_serial_out <= read_bit_q;
    end
    else if (stat_show_q)
    begin
      o_serial_out_en <= 1'b1;
      o_serial_out <= !busy_q;
    end
    else
      o_serial_out_en <= 1'b0;
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  chk_addr_capture: assert property (
    sclk_rise && cs_s && state_q == ST_ADDR |=> addr_q[0] == $past(din_s))
    else $error("address bit not captured");
  chk_read_bit: assert property (
    rd_act_q && sclk_rise ##1 cs_s |-> ##1 o_serial_out == $past(read_bit_q))
    else $error("read bit not driven");
  chk_status_gate: assert property (
    cs_rise && csl_ok && stat_pend_q ##1 cs_s |=> o_serial_out_en)
    else $error("status not presented");
  chk_hiz_deselect: assert property (
    !cs_s |=> !o_serial_out_en)
    else $error("output driven while deselected");
  chk_status_level: assert property (
    cs_s && stat_show_q && !rd_act_q |=> o_serial_out == !$past(busy_q))
    else $error("status level wrong");
  chk_status_clear: assert property (
    cs_fall && start_seen_q && !prog_ok |=> !stat_pend_q && !stat_show_q)
    else $error("status not cleared");
  chk_width_sample: assert property (
    cs_rise |=> x16_q == width_of($past(pins_s[PIN_STRAP])))
    else $error("word width not sampled");
  chk_permit_block: assert property (
    prog_go && !permit_q && !busy_q |=> !busy_q)
    else $error("programming not inhibited");
  chk_prog_runs: assert property (
    busy_q && prog_cnt_q != 24'h000000 |=> busy_q)
    else $error("programming cut short");
  chk_cfg_stable: assert property (
    cs_s && !cs_rise |=> $stable(x16_q) && $stable(permit_q))
    else $error("configuration changed mid command");
  cov_read: cover property (rd_act_q && ff.rd_ready && ff.rd_valid);
  cov_ready: cover property (stat_show_q && !busy_q && o_serial_out_en);
  cov_clear: cover property (cs_fall && start_seen_q && stat_pend_q);
endmodule // sepc_ctrl

// *** rtl/sepc_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sepc_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 8)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  sepc_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic full;
  logic empty;
  // ==========================================================
  // Extra pointer bit separates full from empty
  assign empty = (wptr_q == rptr_q);
  assign full = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
  assign f.wr_ready = !full && !f.flush;
  assign f.rd_valid = !empty;
  assign f.rd_data = mem[rptr_q[AW-1:0]];
  // Pointers; flush drops everything held
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else if (f.flush)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      if (f.wr_valid && f.wr_ready)
        wptr_q <= wptr_q + 1'b1;
      if (f.rd_ready && !empty)
        rptr_q <= rptr_q + 1'b1;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge i_clock)
  begin
    if (f.wr_valid && !full && !f.flush)
      mem[wptr_q[AW-1:0]] <= f.wr_data;
  end
endmodule // sepc_fifo

// *** rtl/sepc_fifo_if.sv ***
// Read-ahead FIFO handshake bundle
`timescale 1ns/100ps
interface sepc_fifo_if #(parameter int WIDTH = 16) ();
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic flush;
  modport fifo (input wr_valid, wr_data, rd_ready, flush,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, flush,
                input wr_ready, rd_valid, rd_data);
endinterface

// *** rtl/sepc_pkg.sv ***
// Shared constants and types for the serial EEPROM pin controller
package sepc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CSL_MIN_NS = 250;
  localparam int CSL_CYC = (CSL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int OUTPUT_DELAY_NS = 40;
  localparam int OUTPUT_DELAY_CYC = OUTPUT_DELAY_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Command layout
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [4:0] OPC_BITS = 5'h02;
  localparam logic [4:0] ADDR_BITS_X8 = 5'h0A;
  localparam logic [4:0] ADDR_BITS_X16 = 5'h09;
  localparam logic [4:0] DATA_BITS_X8 = 5'h08;
  localparam logic [4:0] DATA_BITS_X16 = 5'h10;
  localparam int WORDS = 512;
  localparam int FIFO_DEPTH = 8;
  // Width selection: strap, fixed x8, fixed x16
  localparam logic [1:0] WSEL_STRAP = 2'h0;
  localparam logic [1:0] WSEL_X8 = 2'h1;
  localparam logic [1:0] WSEL_X16 = 2'h2;
  // Pin sync vector positions
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SIN = 2;
  localparam int PIN_STRAP = 3;
  localparam int PIN_PERMIT = 4;
  localparam int PIN_COUNT = 5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_DONE = 3'b101
  } sepc_state_t;
endpackage

// *** rtl/sepc_sync.sv ***
// Two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
module sepc_sync #(parameter int W = 5)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // sepc_sync

// *** test/sepc_host_model.sv ***
// Host controller model driving the three-wire serial bus
`timescale 1ns/100ps
module sepc_host_model
(
  input wire logic i_clock,
  output logic o_chip_select,
  output logic o_serial_clock,
  output logic o_serial_in,
  input wire logic i_serial_out
);
  // ==========================================================
  // Bus parked at time zero: deselected, serial clock low
  initial
  begin
    o_chip_select = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_in = 1'b0;
  end

  // Let a number of system clocks pass
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Deselect; the serial clock stands still between frames
  task automatic deselect(input int n);
    @(posedge i_clock);
    o_chip_select <= 1'b0;
    o_serial_clock <= 1'b0;
    o_serial_in <= ~o_serial_in; // Released data line must not look held
    idle(n);
  endtask

  // Select and give the pin synchronisers time to settle
  task automatic select();
    @(posedge i_clock);
    o_chip_select <= 1'b1;
    idle(8);
  endtask

  // One bit: data set up 4 clocks ahead, 4 high, 4 low, then sample output
  task automatic clock_bit(input logic b, output logic seen);
    @(posedge i_clock);
    o_serial_in <= b;
    idle(4);
    o_serial_clock <= 1'b1;
    idle(4);
    o_serial_clock <= 1'b0;
    idle(4);
    #1 seen = i_serial_out;
  endtask

  // Shift out the low n bits of v, most significant first
  task automatic send(input logic [31:0] v, input int n);
    logic s;
    for (int i = n - 1; i >= 0; i--)
      clock_bit(v[i], s);
  endtask

  // Clock in n output bits; input toggles since it is a don't care here
  task automatic recv(input int n, output logic [31:0] v);
    logic s;
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      clock_bit(i[0], s);
      v = {v[30:0], s};
    end
  endtask
endmodule // sepc_host_model

// *** test/testbench.sv ***
// Self-checking testbench for the serial EEPROM pin controller
`timescale 1ns/100ps
module testbench;
  import sepc_pkg::*;
  // Short program time keeps the run brief
  localparam int PROG = 200;
  localparam int LIMIT = 40000;
  logic clk, rst, strap, permit, use2;
  logic cs, sclk, sin, so, so_en, so_raw, cs1, cs2, out1, en1, out2, en2;
  int fails, num_checks, cycles;

  // ==========================================================
  // Clock and pin steering between the two variants
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  assign cs1 = cs & ~use2;
  assign cs2 = cs & use2;
  assign so_raw = use2 ? out2 : out1;
  assign so_en = use2 ? en2 : en1;
  // Undriven line shows the opposite of its last level so stale data cannot pass
  assign so = so_en ? so_raw : ~so_raw;

  sepc_host_model host (.i_clock(clk), .o_chip_select(cs), .o_serial_clock(sclk),
    .o_serial_in(sin), .i_serial_out(so));
  sepc_ctrl #(.PROG_CYCLES(PROG)) DUT (.i_clock(clk), .i_sys_rst(rst),
    .i_chip_select(cs1), .i_serial_clock(sclk), .i_serial_in(sin),
    .i_word_width_strap(strap), .i_program_permit(permit),
    .o_serial_out(out1), .o_serial_out_en(en1));
  // Fixed x8 variant without permit pin; its strap and permit must be ignored
  sepc_ctrl #(.WIDTH_SEL(WSEL_X8), .HAS_PERMIT(1'b0), .PROG_CYCLES(PROG)) DUT2 (
    .i_clock(clk), .i_sys_rst(rst), .i_chip_select(cs2), .i_serial_clock(sclk),
    .i_serial_in(sin), .i_word_width_strap(strap), .i_program_permit(permit),
    .o_serial_out(out2), .o_serial_out_en(en2));

  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= LIMIT)
    begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared steps
  task automatic poll(output logic e, output logic v);
    host.deselect(40);
    host.select();
    #1 e = so_en;
    v = so;
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (so !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // Start bit then deselect drops the status drive
  task automatic clear_status();
    logic e, v;
    host.send(32'h1, 1);
    poll(e, v);
    check(e, 1'b0);
    host.deselect(8);
  endtask

  // Read with the strap flipped mid-command; width must not change
  task automatic rd(input logic [31:0] cmd, input int n, input int nd,
                    output logic [31:0] d);
    host.select();
    strap <= ~strap;
    host.send(cmd, n);
    check(so_en, 1'b1);
    check(so, 1'b0);
    host.recv(nd, d);
    host.deselect(40);
    strap <= ~strap;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_write_status();
    logic e, v;
    int n;
    host.select();
    host.send({1'b1, OPC_WRITE, 9'h1A5, 16'hA55A}, 28);
    poll(e, v);
    check(e, 1'b1);
    check(v, 1'b0);
    wait_ready(n);
    check(so, 1'b1);
    check(n > 100, 1'b1);
    clear_status();
  endtask

  task automatic t_reads();
    logic [31:0] d;
    rd({1'b1, OPC_READ, 9'h1A5}, 12, 16, d);
    check(d, 32'hA55A);
    host.deselect(2);
    strap <= 1'b0;
    rd({1'b1, OPC_READ, 10'h34A}, 13, 16, d);
    check(d, 32'hA55A);
    host.idle(1);
    strap <= 1'b1;
  endtask

  task automatic t_protect();
    logic e, v;
    logic [31:0] d;
    permit <= 1'b0;
    host.select();
    host.send({1'b1, OPC_WRITE, 9'h1A5, 16'h0F0F}, 28);
    poll(e, v);
    check(e, 1'b0);
    host.deselect(PROG + 20);
    permit <= 1'b1;
    rd({1'b1, OPC_READ, 9'h1A5}, 12, 16, d);
    check(d, 32'hA55A);
  endtask

  // Erase forces the word to all ones and reports status like a write
  task automatic t_erase();
    logic e, v;
    logic [31:0] d;
    int n;
    host.select();
    host.send({1'b1, OPC_ERASE, 9'h1A5}, 12);
    poll(e, v);
    check(e, 1'b1);
    check(v, 1'b0);
    wait_ready(n);
    check(so, 1'b1);
    clear_status();
    rd({1'b1, OPC_READ, 9'h1A5}, 12, 16, d);
    check(d, 32'hFFFF);
  endtask

  task automatic t_hold_low();
    logic [31:0] d;
    int n;
    host.select();
    host.send({1'b1, OPC_WRITE, 9'h002, 16'h1234}, 28);
    host.deselect(1);
    n = 0;
    repeat (PROG + 50)
    begin
      @(posedge clk);
      #1 if (so_en !== 1'b0) n++;
    end
    check(n, 0);
    host.select();
    check(so_en, 1'b1);
    check(so, 1'b1);
    clear_status();
    rd({1'b1, OPC_READ, 9'h002}, 12, 16, d);
    check(d, 32'h1234);
  endtask

  task automatic t_fixed();
    logic e, v;
    logic [31:0] d;
    int n;
    use2 <= 1'b1;
    permit <= 1'b0;
    host.select();
    host.send({1'b1, OPC_WRITE, 10'h011, 8'hC3}, 21);
    poll(e, v);
    check(e, 1'b1);
    wait_ready(n);
    check(so, 1'b1);
    clear_status();
    rd({1'b1, OPC_READ, 10'h011}, 13, 8, d);
    check(d, 32'hC3);
    use2 <= 1'b0;
    permit <= 1'b1;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    strap = 1'b1;
    permit = 1'b1;
    use2 = 1'b0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    host.deselect(10);
    t_write_status();
    t_reads();
    t_protect();
    t_erase();
    t_hold_low();
    t_fixed();
    stop_test();
  end
endmodule // testbench
